// file: logic/ota_char_map.sv
/*
  ota_char_map: character code to glyph source selection.
  Assumes code and settings are stable at the display clock.
*/
`timescale 1ns/1ns
`default_nettype none
module ota_char_map
  import ota_pkg::*;
(
  input  wire logic     clk,
  input  wire logic     rstn,
  input  wire logic [7:0] code,
  input  wire ota_set_t set,
  input  wire logic     caption_mode,
  input  wire logic     alt_sel,
  output logic          redef_hit,
  output logic [4:0]    redef_idx,
  output logic [1:0]    char_set,
  output logic [7:0]    nat_index
);
  logic hit_c;
  logic [4:0] ridx_c;
  always_comb begin
    hit_c  = set.redef_char_enable && code >= REDEF_LO && code <= REDEF_HI;
    // special symbols take two slots, so only 16 distinct ones
    ridx_c = set.redef_planes_select ? {code[3:0], 1'b0} : code[4:0];
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      redef_hit <= 1'b0;
      redef_idx <= 5'h00;
      char_set  <= 2'h0;
      nat_index <= 8'h00;
    end else begin
      redef_hit <= hit_c;
      redef_idx <= ridx_c;
      // caption mode shows only the basic set
      if (caption_mode || !set.alt_set_enable || !alt_sel)
        char_set <= set.basic_set_select;
      else
        char_set <= set.alt_set_select;
      nat_index <= {set.region_select, set.national_table_select,
                    set.language_ctrl_bit_a, set.language_ctrl_bit_b, set.language_ctrl_bit_c};
    end
  end
endmodule
`default_nettype wire

// file: logic/ota_pkg.sv
/*
  ota_pkg: shared constants and types for the text area and character
  generation block. Assumes a 100 MHz clock shared by bus and display logic.
*/
`default_nettype none
package ota_pkg;
  localparam int unsigned CLK_MHZ        = 100;
  localparam int unsigned SCR_START_US   = 8;
  localparam int unsigned SCR_LEN_US     = 56;
  localparam int unsigned SCR_START_CYC  = SCR_START_US * CLK_MHZ;
  localparam int unsigned SCR_LEN_CYC    = SCR_LEN_US * CLK_MHZ;
  localparam int unsigned DOT_MHZ        = 12;
  // one character is 12 dots of the 12 MHz display clock, 1 us
  localparam int unsigned CHAR_CYC       = CLK_MHZ;
  localparam int unsigned QCHAR_CYC      = CHAR_CYC / 4;
  localparam int unsigned DOT_CYC        = CLK_MHZ / DOT_MHZ;
  localparam int unsigned CHAR_DOTS      = 12;
  localparam int unsigned MAX_CHARS      = 48;
  localparam int unsigned TXT_LINES      = 256;
  localparam int unsigned SCR_LINE_F1    = 9;
  localparam int unsigned SCR_LINE_F2    = 321;
  localparam int unsigned TAS_MIN        = 8;
  localparam int unsigned TAS_MAX        = 64;
  localparam int unsigned VOL_MIN        = 4;
  localparam int unsigned VOL_MAX        = 64;
  localparam logic [7:0]  REDEF_LO       = 8'h80;
  localparam logic [7:0]  REDEF_HI       = 8'h9F;
  localparam logic [15:0] REDEF_RAM_BASE = 16'h8800;
  localparam int unsigned REDEF_ROWS     = 16;
  localparam int unsigned REDEF_CHARS    = 32;
  // register byte addresses
  localparam logic [7:0] A_POS   = 8'h00;
  localparam logic [7:0] A_SET   = 8'h04;
  localparam logic [7:0] A_STAT  = 8'h08;
  localparam logic [7:0] A_RAM   = 8'h0C;
  localparam logic [7:0] A_CODE  = 8'h10;
  localparam logic [7:0] A_PIX   = 8'h14;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_DE = 2'h3;
  // field positions in the position word
  localparam int unsigned P_TAS = 0;
  localparam int unsigned P_HOP = 6;
  localparam int unsigned P_TAE = 8;
  localparam int unsigned P_VOL = 16;
  localparam int unsigned P_MOD = 24;
  localparam int unsigned P_MAT = 25;
  localparam int unsigned P_PL2 = 27;

  typedef enum logic [1:0] {
    OTA_M9  = 2'h0,
    OTA_M10 = 2'h1,
    OTA_M13 = 2'h2,
    OTA_M16 = 2'h3
  } ota_matrix_t;

  typedef struct packed {
    logic [5:0]  text_start_coarse;
    logic [1:0]  text_start_fine;
    logic [5:0]  text_end_char;
    logic [5:0]  text_vertical_offset;
    logic        caption_mode;
    ota_matrix_t matrix;
    logic        two_plane;
  } ota_pos_t;

  typedef struct packed {
    logic [1:0] basic_set_select;
    logic [1:0] alt_set_select;
    logic       alt_set_enable;
    logic [2:0] alt_set_language;
    logic [3:0] national_table_select;
    logic       region_select;
    logic       language_ctrl_bit_a;
    logic       language_ctrl_bit_b;
    logic       language_ctrl_bit_c;
    logic       redef_char_enable;
    logic       redef_planes_select;
  } ota_set_t;

  localparam logic [31:0] POS_RST = 32'h0000_0000;
  localparam logic [31:0] SET_RST = 32'h0000_0000;
endpackage
`default_nettype wire

// file: logic/ota_sync2.sv
/*
  ota_sync2: two-flop synchroniser for one level.
  Assumes the input is asynchronous to clk.
*/
`timescale 1ns/1ns
`default_nettype none
module ota_sync2 (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic d,
  output logic      q
);
  logic s1_r;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1_r <= 1'b0;
      q    <= 1'b0;
    end else begin
      s1_r <= d;
      q    <= s1_r;
    end
  end
endmodule
`default_nettype wire

// file: logic/ota_top.sv
/*
  ota_top: text area positioning, screen colour window, character set
  selection and redefinable character RAM behind an AXI4-Lite slave.
  Assumes hsync/vsync are asynchronous pins, active high at their leading edge.
*/
// Chosen here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module ota_top
  import ota_pkg::*;
#(
  parameter int unsigned LINE_W = 10
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        hsync,
  input  wire logic        vsync,
  input  wire logic [7:0]  char_code,
  input  wire logic        char_alt,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             screen_area,
  output logic             text_area,
  output logic             char_fetch,
  output logic [5:0]       char_col,
  output logic [3:0]       glyph_line,
  output logic             display_busy,
  output logic             pixel_on,
  output logic [1:0]       char_set,
  output logic [7:0]       nat_index,
  output logic [4:0]       redef_idx
);
  logic hs_s, vs_s, hs_d_r, vs_d_r, hs_edge, vs_edge;
  ota_sync2 u_hs (.clk(clk), .rstn(rstn), .d(hsync), .q(hs_s));
  ota_sync2 u_vs (.clk(clk), .rstn(rstn), .d(vsync), .q(vs_s));
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hs_d_r <= 1'b0;
      vs_d_r <= 1'b0;
    end else begin
      hs_d_r <= hs_s;
      vs_d_r <= vs_s;
    end
  end
  assign hs_edge = hs_s && !hs_d_r;
  assign vs_edge = vs_s && !vs_d_r;

  // software copy of positions, applied only at field start; set_r applies at once
  ota_pos_t pos_sw_r, pos_r;
  ota_set_t set_r;
  logic [LINE_W-1:0] busy_cnt_r;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      pos_r <= ota_pos_t'(POS_RST[$bits(ota_pos_t)-1:0]);
    else if (vs_edge)
      pos_r <= pos_sw_r;
  end

  // horizontal: cycle counter from hsync leading edge
  logic [12:0] hcnt_r;
  logic [12:0] txt_start_c;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      hcnt_r <= 13'h0000;
    else if (hs_edge)
      hcnt_r <= 13'h0000;
    else if (hcnt_r != 13'h1FFF)
      hcnt_r <= hcnt_r + 13'h0001;
  end
  // coarse whole chars plus fine quarter chars
  assign txt_start_c = 13'(pos_r.text_start_coarse * CHAR_CYC) + 13'(pos_r.text_start_fine * QCHAR_CYC);

  // vertical: line counter from vsync leading edge, odd field flag
  logic [LINE_W-1:0] vcnt_r;
  logic field2_r;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      vcnt_r   <= '0;
      field2_r <= 1'b0;
    end else if (vs_edge) begin
      vcnt_r   <= '0;
      field2_r <= !field2_r;
    end else if (hs_edge) begin
      vcnt_r <= vcnt_r + LINE_W'(1);
    end
  end

  logic [LINE_W-1:0] scr_first_c;
  // 625-line numbering; field 2 line 321 is line 8 of its field
  assign scr_first_c = field2_r ? LINE_W'(SCR_LINE_F2 - 313) : LINE_W'(SCR_LINE_F1 - 1);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      screen_area <= 1'b0;
    else
      screen_area <= hcnt_r >= 13'(SCR_START_CYC) && hcnt_r < 13'(SCR_START_CYC + SCR_LEN_CYC)
                     && vcnt_r >= scr_first_c && !vs_s;
  end

  // text area window
  logic v_in_c, h_in_c, ch_tick_c;
  logic [12:0] hrel_c;
  logic [LINE_W-1:0] vrel_c;
  logic [6:0] ch_pos_r;
  logic [6:0] ch_lim_c;
  assign vrel_c = vcnt_r - LINE_W'(pos_r.text_vertical_offset);
  assign v_in_c = vcnt_r >= LINE_W'(pos_r.text_vertical_offset) && vrel_c < LINE_W'(TXT_LINES);
  assign hrel_c = hcnt_r - txt_start_c;
  assign h_in_c = hcnt_r >= txt_start_c && hrel_c < 13'(MAX_CHARS * CHAR_CYC);
  assign ch_tick_c = h_in_c && hrel_c == 13'(hrel_c / 13'(CHAR_CYC) * 13'(CHAR_CYC));
  assign ch_lim_c = (pos_r.text_end_char > 6'(MAX_CHARS)) ? 7'(MAX_CHARS) : {1'b0, pos_r.text_end_char};
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      ch_pos_r <= 7'h00;
    else if (hs_edge)
      ch_pos_r <= 7'h00;
    else if (ch_tick_c && ch_pos_r < 7'(MAX_CHARS))
      ch_pos_r <= ch_pos_r + 7'h01;
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      text_area  <= 1'b0;
      char_fetch <= 1'b0;
      char_col   <= 6'h00;
    end else begin
      text_area  <= v_in_c && h_in_c && hrel_c < 13'(ch_lim_c * CHAR_CYC);
      char_fetch <= v_in_c && ch_tick_c && ch_pos_r < ch_lim_c;
      char_col   <= ch_pos_r[5:0];
    end
  end

  // glyph line within a 16-line row; short matrices padded blank
  logic [3:0] gl_c;
  logic gl_ok_c;
  always_comb begin
    gl_c = vrel_c[3:0];
    case (pos_r.matrix)
      OTA_M9:  gl_ok_c = gl_c < 4'h9;
      OTA_M10: gl_ok_c = gl_c < 4'hA;
      OTA_M13: gl_ok_c = gl_c < 4'hD;
      OTA_M16: gl_ok_c = 1'b1;
      default: gl_ok_c = 1'b0;
    endcase
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      glyph_line <= 4'h0;
    else
      glyph_line <= gl_c;
  end

  // busy: counts text-area lines; the flag, not the count, is suppressed when offset is zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      display_busy <= 1'b0;
    else
      display_busy <= v_in_c && pos_r.text_vertical_offset != 6'h00;
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      busy_cnt_r <= '0;
    else if (vs_edge)
      busy_cnt_r <= '0;
    else if (hs_edge && v_in_c)
      busy_cnt_r <= busy_cnt_r + LINE_W'(1);
  end

  // redefinable character RAM: 32 chars x 16 rows x 12 bits
  logic [11:0] ram_r [REDEF_CHARS*REDEF_ROWS];
  logic [8:0]  ram_addr_r;
  logic        map_hit;
  logic [4:0]  map_idx;
  logic [11:0] ram_row_c;
  logic        cap_2pl_c;
  ota_char_map u_map (
    .clk(clk), .rstn(rstn), .code(char_code), .set(set_r),
    .caption_mode(pos_r.caption_mode), .alt_sel(char_alt),
    .redef_hit(map_hit), .redef_idx(map_idx), .char_set(char_set), .nat_index(nat_index)
  );
  // every supported matrix fits one 12x16 slot
  assign ram_row_c = ram_r[{map_idx, glyph_line}];
  // two planes only allowed in caption mode
  assign cap_2pl_c = pos_r.two_plane && pos_r.caption_mode;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pixel_on  <= 1'b0;
      redef_idx <= 5'h00;
    end else begin
      redef_idx <= map_idx;
      // rom glyph source is outside; only redefinable pixels shown here
      pixel_on  <= map_hit && gl_ok_c && text_area && (ram_row_c != 12'h000 || cap_2pl_c);
    end
  end

  // AXI4-Lite slave
  logic aw_ok_r, w_ok_r;
  logic [7:0]  aw_r;
  logic [31:0] wd_r;
  logic [3:0]  ws_r;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      aw_ok_r <= 1'b0;
      w_ok_r  <= 1'b0;
      aw_r    <= 8'h00;
      wd_r    <= 32'h0000_0000;
      ws_r    <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OK;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok_r <= 1'b1;
        aw_r    <= s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok_r <= 1'b1;
        wd_r   <= s_axi_wdata;
        ws_r   <= s_axi_wstrb;
      end
      if (aw_ok_r && w_ok_r && !s_axi_bvalid) begin
        aw_ok_r      <= 1'b0;
        w_ok_r       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_r == A_POS || aw_r == A_SET || aw_r == A_RAM || aw_r == A_PIX) ? RESP_OK : RESP_DE;
      end else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end
  assign s_axi_awready = !aw_ok_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_ok_r && !s_axi_bvalid;
  logic do_wr;
  assign do_wr = aw_ok_r && w_ok_r && !s_axi_bvalid;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pos_sw_r   <= ota_pos_t'(POS_RST[$bits(ota_pos_t)-1:0]);
      set_r      <= ota_set_t'(SET_RST[$bits(ota_set_t)-1:0]);
      ram_addr_r <= 9'h000;
    end else if (do_wr && ws_r[0]) begin
      if (aw_r == A_POS)
        pos_sw_r <= '{wd_r[P_TAS+:6], wd_r[P_HOP+:2], wd_r[P_TAE+:6], wd_r[P_VOL+:6],
                      wd_r[P_MOD], ota_matrix_t'(wd_r[P_MAT+:2]), wd_r[P_PL2]};
      else if (aw_r == A_SET)
        set_r <= ota_set_t'(wd_r[$bits(ota_set_t)-1:0]);
      else if (aw_r == A_RAM)
        ram_addr_r <= wd_r[8:0];
    end
  end
  // pixel word: bits 7:0 low byte (even), 11:8 upper nibble (odd)
  always_ff @(posedge clk) begin
    if (do_wr && aw_r == A_PIX) begin
      if (ws_r[0])
        ram_r[ram_addr_r][7:0] <= wd_r[7:0];
      if (ws_r[1])
        ram_r[ram_addr_r][11:8] <= wd_r[11:8];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OK;
      case (s_axi_araddr[7:0])
        A_POS:   s_axi_rdata <= {4'h0, pos_sw_r.two_plane, pos_sw_r.matrix, pos_sw_r.caption_mode, 2'h0,
                                 pos_sw_r.text_vertical_offset, 2'h0, pos_sw_r.text_end_char,
                                 pos_sw_r.text_start_fine, pos_sw_r.text_start_coarse};
        A_SET:   s_axi_rdata <= 32'(set_r);
        A_STAT:  s_axi_rdata <= {field2_r, display_busy, 30'(busy_cnt_r)};
        A_RAM:   s_axi_rdata <= 32'(ram_addr_r);
        A_CODE:  s_axi_rdata <= {16'h0000, nat_index, 1'b0, char_set, redef_idx};
        A_PIX:   s_axi_rdata <= 32'(ram_r[ram_addr_r]);
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_DE;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
  assign s_axi_arready = !s_axi_rvalid;

  // positioning settings hold across a field
  pos_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    !vs_edge |=> $stable(pos_r)) else $error("positions changed mid field");
  zero_busy_a: assert property (@(posedge clk) disable iff (!rstn)
    pos_r.text_vertical_offset == 6'h00 |=> !display_busy) else $error("busy with zero offset");
  fetch_lim_a: assert property (@(posedge clk) disable iff (!rstn)
    char_fetch |-> char_col < 6'(MAX_CHARS)) else $error("fetch beyond row");
  redef_en_a: assert property (@(posedge clk) disable iff (!rstn)
    !set_r.redef_char_enable [*2] |-> !map_hit) else $error("remap while disabled");
  scr_early_a: assert property (@(posedge clk) disable iff (!rstn)
    hcnt_r < 13'(SCR_START_CYC) |=> !screen_area) else $error("screen colour too early");
  cap_basic_a: assert property (@(posedge clk) disable iff (!rstn)
    pos_r.caption_mode |=> char_set == $past(set_r.basic_set_select))
    else $error("caption not basic set");
  txt_vert_a: assert property (@(posedge clk) disable iff (!rstn)
    vcnt_r < LINE_W'(pos_r.text_vertical_offset) |=> !text_area) else $error("text above offset");
  b_after_a: assert property (@(posedge clk) disable iff (!rstn)
    do_wr |=> s_axi_bvalid) else $error("write response missing");
endmodule
`default_nettype wire

// file: tb/osd_text_area_and_charset_tb.sv
/*
  osd_text_area_and_charset_tb: register bus, screen window and charset checks.
  Assumes ota_top and ota_sync_model; read results go through a queue.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin num_errors++; $display("Error at %0t: got %0h expected %0h", $time, g, e); end end
module osd_text_area_and_charset_tb import ota_pkg::*;;
  localparam int TMO = 95000;
  localparam int TXS = 9 * CHAR_CYC + QCHAR_CYC;
  localparam int TAE_N = 40;
  logic        clk, rstn, go, char_alt, hs_d, sa_d, ta_d;
  logic        text_area, char_fetch, display_busy, pixel_on;
  logic [5:0]  char_col;
  logic [3:0]  glyph_line;
  logic [7:0]  char_code, lines, line_no, nat_index, nat_e;
  logic [1:0]  char_set, cs_e, bresp, rresp;
  logic [4:0]  redef_idx;
  logic        hsync, vsync, busy, screen_area;
  logic [31:0] awaddr, wdata, araddr, rdata, pos_w, r;
  logic [31:0] seed = 32'h4E;
  logic [3:0]  wstrb;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [33:0] exp_q[$];
  logic [33:0] got_e;
  int          scr_q[$];
  int          num_errors = 0;
  int          checks = 0;
  int          cyc = 0;
  int          hs_t = 0;
  int          wid = 0;
  int          nf = 0;
  int          tw = 0;
  int          exp_w;
  ota_set_t    s;

  ota_top #(.LINE_W(10)) dut (
    .clk(clk), .rstn(rstn), .hsync(hsync), .vsync(vsync), .char_code(char_code), .char_alt(char_alt),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .screen_area(screen_area), .text_area(text_area), .char_fetch(char_fetch),
    .char_col(char_col), .glyph_line(glyph_line), .display_busy(display_busy), .pixel_on(pixel_on),
    .char_set(char_set), .nat_index(nat_index),
    .redef_idx(redef_idx)
  );
  ota_sync_model sm (
    .clk(clk), .go(go), .lines(lines), .hsync(hsync), .vsync(vsync), .line_no(line_no), .busy(busy)
  );

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic conclude();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // aw and w may be taken on different edges
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic da, dw, ta, tw;
    da = 1'b0;
    dw = 1'b0;
    awaddr <= {24'h0, a};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(da && dw)) begin
      @(negedge clk);
      ta = awready && !da;
      tw = wready && !dw;
      @(posedge clk);
      if (ta) begin
        da = 1'b1;
        awvalid <= 1'b0;
      end
      if (tw) begin
        dw = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(negedge clk); while (!bvalid);
    `CHK(bresp, er)
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    exp_q.push_back(e);
    araddr <= {24'h0, a};
    arvalid <= 1'b1;
    do @(negedge clk); while (!arready);
    @(posedge clk);
    arvalid <= 1'b0;
    do @(negedge clk); while (!rvalid);
    @(posedge clk);
  endtask

  task automatic settle();
    repeat (5) @(posedge clk);
    @(negedge clk);
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == TMO) begin
      num_errors++;
      conclude();
    end
  end

  // read results, oldest note first
  always @(posedge clk) begin
    if (rstn && rvalid && rready) begin
      got_e = (exp_q.size() > 0) ? exp_q.pop_front() : 34'h0;
      `CHK({rresp, rdata}, got_e)
    end
  end

  always @(posedge clk) begin
    hs_d <= hsync;
    sa_d <= screen_area;
    hs_t <= (hsync && !hs_d) ? 0 : hs_t + 1;
    wid <= screen_area ? wid + 1 : 0;
    if (screen_area === 1'b1 && sa_d === 1'b0) `CHK(hs_t >= SCR_START_CYC && hs_t <= SCR_START_CYC + 6, 1'b1)
    if (screen_area === 1'b0 && sa_d === 1'b1 && scr_q.size() > 0) begin
      exp_w = scr_q.pop_front();
      `CHK(wid, exp_w)
    end
    ta_d <= text_area;
    tw <= text_area ? tw + 1 : 0;
    nf <= (hsync && !hs_d) ? 0 : nf + int'(char_fetch);
    if (hsync && !hs_d && line_no > 8'h04) `CHK(nf, TAE_N)
    if (char_fetch === 1'b1) `CHK(char_col, 6'(nf))
    if (text_area === 1'b1 && ta_d === 1'b0) `CHK(hs_t >= TXS && hs_t <= TXS + 6, 1'b1)
    if (text_area === 1'b0 && ta_d === 1'b1 && line_no < lines) `CHK(tw, TAE_N * CHAR_CYC)
  end

  initial begin
    rstn = 1'b0;
    go = 1'b0;
    char_code = 8'h00;
    char_alt = 1'b0;
    awaddr = 32'h0;
    awvalid = 1'b0;
    wdata = 32'h0;
    wstrb = 4'hF;
    wvalid = 1'b0;
    bready = 1'b1;
    araddr = 32'h0;
    arvalid = 1'b0;
    rready = 1'b1;
    lines = 8'h0C;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(A_POS, {RESP_OK, POS_RST});
    rd(A_SET, {RESP_OK, SET_RST});
    rd(8'h18, {RESP_DE, 32'h0});
    wr(8'h1C, xs(), RESP_DE);
    pos_w = (32'h9 << P_TAS) | (32'h1 << P_HOP) | (32'h28 << P_TAE) | (32'h4 << P_VOL) | (32'(OTA_M10) << P_MAT);
    wr(A_POS, pos_w, RESP_OK);
    rd(A_POS, {RESP_OK, pos_w});
    repeat (3) scr_q.push_back(SCR_LEN_CYC);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      r = xs();
      s = ota_set_t'(r[17:0]);
      s.basic_set_select = 2'(k);
      s.alt_set_select = 2'(3 - k);
      s.alt_set_enable = k[0];
      s.redef_char_enable = 1'b1;
      s.redef_planes_select = 1'b0;
      wr(A_SET, {14'h0, s}, RESP_OK);
      rd(A_SET, {RESP_OK, 14'h0, s});
      char_alt <= 1'b0;
      char_code <= {3'b100, r[24:20]};
      settle();
      nat_e = {s.region_select, s.national_table_select, s.language_ctrl_bit_a, s.language_ctrl_bit_b, s.language_ctrl_bit_c};
      `CHK(char_set, s.basic_set_select)
      `CHK(nat_index, nat_e)
      `CHK(redef_idx, r[24:20])
      @(posedge clk);
      char_alt <= 1'b1;
      settle();
      cs_e = s.alt_set_enable ? s.alt_set_select : s.basic_set_select;
      `CHK(char_set, cs_e)
      @(posedge clk);
    end
    char_code <= 8'h85;
    wr(A_RAM, 32'h50, RESP_OK);
    wr(A_PIX, 32'h0, RESP_OK);
    wr(A_RAM, 32'h51, RESP_OK);
    wstrb <= 4'h1;
    wr(A_PIX, 32'hA5C, RESP_OK);
    wstrb <= 4'h2;
    wr(A_PIX, 32'h300, RESP_OK);
    wstrb <= 4'hF;
    rd(A_PIX, {RESP_OK, 32'h35C});
    rd(A_RAM, {RESP_OK, 32'h51});
    wait (line_no == 8'h03);
    repeat (1000) @(negedge clk);
    `CHK(display_busy, 1'b0)
    wait (line_no == 8'h04);
    repeat (1000) @(negedge clk);
    `CHK(screen_area, 1'b0)
    `CHK(display_busy, 1'b1)
    `CHK({glyph_line, pixel_on}, 5'h00)
    wait (line_no == 8'h05);
    repeat (1000) @(negedge clk);
    `CHK({glyph_line, pixel_on}, 5'h03)
    @(posedge clk);
    rd(A_STAT, {RESP_OK, 32'hC000_0001});
    pos_w = pos_w | (32'h1 << P_MOD) | (32'h10 << P_TAE);
    wr(A_POS, pos_w, RESP_OK);
    rd(A_POS, {RESP_OK, pos_w});
    wait (line_no == lines);
    @(posedge vsync);
    #1;
    `CHK(screen_area, 1'b1)
    repeat (6) @(negedge clk);
    `CHK(screen_area, 1'b0)
    wait (!busy);
    `CHK(scr_q.size(), 0)
    @(posedge clk);
    s.basic_set_select = 2'h2;
    s.alt_set_select = 2'h2;
    s.alt_set_enable = 1'b1;
    wr(A_SET, {14'h0, s}, RESP_OK);
    settle();
    `CHK(char_set, 2'h2)
    conclude();
  end
endmodule
`default_nettype wire

// file: tb/ota_sync_model.sv
/*
  ota_sync_model: deflection sync source facing the display block.
  Assumes go is pulsed for one clock to start a field.
*/
`timescale 1ns/1ns
`default_nettype none
module ota_sync_model #(
  parameter int LINE_CYC = 6500,
  parameter int HS_CYC   = 470,
  parameter int VS_LINES = 2
) (
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic [7:0] lines,
  output logic            hsync,
  output logic            vsync,
  output logic [7:0]      line_no,
  output logic            busy
);
  initial begin
    hsync = 1'b0;
    vsync = 1'b0;
    line_no = 8'h00;
    busy = 1'b0;
    forever begin
      @(posedge clk iff go);
      busy = 1'b1;
      // skew keeps pin edges away from the sampling edge
      #3;
      vsync = 1'b1;
      for (int i = 0; i <= int'(lines); i++) begin
        if (i == VS_LINES) vsync = 1'b0;
        line_no = 8'(i);
        hsync = 1'b1;
        #(HS_CYC * 10);
        hsync = 1'b0;
        if (i == int'(lines)) #((3000 - HS_CYC) * 10);
        else #((LINE_CYC - HS_CYC) * 10);
      end
      // next field starts early, inside the screen window
      vsync = 1'b1;
      #1000;
      vsync = 1'b0;
      busy = 1'b0;
    end
  end
endmodule
`default_nettype wire
